// File: rtl/asi_idle_regs.sv
`timescale 1ns/1ns

// ---------------------------------------------------------------
// Word FIFO in the received data path
// ---------------------------------------------------------------
module asi_word_fifo #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 32
) (
   input  wire logic             ref_clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output      logic             in_ready,
   output      logic [WIDTH-1:0] out_data,
   output      logic             out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);

   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
         $error("FIFO depth must be a power of two, at least 2");
   end

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wr_ptr;
      logic [AW-1:0]               rd_ptr;
      logic [AW:0]                 count;
   } fifo_state_t;

   fifo_state_t s_q;
   fifo_state_t s_d;
   logic        push;
   logic        pop;

   // Honest flags straight from the fill count
   assign in_ready  = (s_q.count != (AW+1)'(DEPTH));
   assign out_valid = (s_q.count != '0);
   assign out_data  = s_q.mem[s_q.rd_ptr];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // Pointer and count update
   always_comb begin
      s_d = s_q;
      if (push) begin
         s_d.mem[s_q.wr_ptr] = in_data;
         s_d.wr_ptr          = s_q.wr_ptr + 1'b1;
      end
      if (pop)
         s_d.rd_ptr = s_q.rd_ptr + 1'b1;
      if (push && !pop)
         s_d.count = s_q.count + 1'b1;
      else if (pop && !push)
         s_d.count = s_q.count - 1'b1;
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   property p_no_overflow;
      @(posedge ref_clk) disable iff (!rst_n)
         s_q.count == (AW+1)'(DEPTH) |-> !push;
   endproperty
   a_no_overflow: assert property (p_no_overflow)
      else $error("FIFO written while full");
endmodule

// ---------------------------------------------------------------
// Idle-character substitution and register bank
// ---------------------------------------------------------------
module asi_idle_regs #(
   parameter int DATA_W = asi_regs_pkg::IDLE_W,
   parameter int DEPTH  = asi_regs_pkg::FIFO_DEPTH
) (
   input  wire logic              ref_clk,
   input  wire logic              rst_n,
   // Decoded words from the receiver
   input  wire logic [DATA_W-1:0] rx_data,
   input  wire logic              rx_valid,
   output      logic              rx_ready,
   input  wire logic              asi_mode,
   input  wire logic [1:0]        op_state,
   // Parallel stream towards the host
   output      logic [DATA_W-1:0] out_data,
   output      logic              out_valid,
   output      logic              out_is_idle,
   input  wire logic              out_ready,
   // Loop-through enable pin and resulting state
   input  wire logic              loop_pin,
   output      logic              loop_thru_en,
   // Register port of the management interface
   input  wire logic [7:0]        reg_addr,
   input  wire logic              reg_wr,
   input  wire logic [7:0]        reg_wdata,
   input  wire logic              reg_rd,
   output      logic [7:0]        reg_rdata
);
   initial begin
      if (DATA_W != asi_regs_pkg::IDLE_W)
         $error("Stream width must match the idle character width");
   end

   typedef struct packed {
      logic [DATA_W-1:0] idle;
      logic              loop_en;
      logic              init_done;
      logic [DATA_W-1:0] out_data;
      logic              out_valid;
      logic              out_idle;
      logic [7:0]        rdata;
      logic              ever_wr;
   } regs_state_t;

   regs_state_t       s_q;
   regs_state_t       s_d;
   logic [DATA_W-1:0] f_data;
   logic              f_valid;
   logic              f_pop;
   logic              slot_free;
   logic [7:0]        status;

   // ------------------------------------------------------------
   // Received words wait here while the host stalls
   // ------------------------------------------------------------
   asi_word_fifo #(
      .WIDTH (DATA_W),
      .DEPTH (DEPTH)
   ) u_fifo (
      .ref_clk   (ref_clk),
      .rst_n     (rst_n),
      .in_data   (rx_data),
      .in_valid  (rx_valid),
      .in_ready  (rx_ready),
      .out_data  (f_data),
      .out_valid (f_valid),
      .out_ready (f_pop)
   );

   // Output register may load when empty or being taken
   assign slot_free = !s_q.out_valid || out_ready;
   assign f_pop     = slot_free && f_valid;

   // Status word; bits 7:6 stay zero
   assign status = {2'b00, s_q.loop_en,
                    op_state,
                    asi_regs_pkg::VARIANT_ID};

   // Next state of stream, registers and read data
   always_comb begin
      s_d = s_q;
      // Loop enable follows the pin once, on the first edge after reset
      if (!s_q.init_done) begin
         s_d.init_done = 1'b1;
         s_d.loop_en   = loop_pin;
      end
      // Stream stage: real data first, idle fill only in ASI mode
      if (slot_free) begin
         if (f_valid) begin
            s_d.out_data  = f_data;
            s_d.out_valid = 1'b1;
            s_d.out_idle  = 1'b0;
         end else if (asi_mode) begin
            s_d.out_data  = s_q.idle;
            s_d.out_valid = 1'b1;
            s_d.out_idle  = 1'b1;
         end else begin
            s_d.out_valid = 1'b0;
            s_d.out_idle  = 1'b0;
         end
      end
      // Writes; reserved high bits are dropped
      if (reg_wr) begin
         unique case (reg_addr)
            asi_regs_pkg::IDLE_LOW_OFS: begin
               s_d.idle[7:0] = reg_wdata;
               s_d.ever_wr   = 1'b1;
            end
            asi_regs_pkg::IDLE_HIGH_OFS: begin
               s_d.idle[9:8] = reg_wdata[1:0];
               s_d.ever_wr   = 1'b1;
            end
            default: ;
         endcase
      end
      // Reads; unmapped addresses return zero
      if (reg_rd) begin
         unique case (reg_addr)
            asi_regs_pkg::IDLE_LOW_OFS:
               s_d.rdata = s_q.idle[7:0];
            asi_regs_pkg::IDLE_HIGH_OFS:
               s_d.rdata = {6'h00, s_q.idle[9:8]};
            asi_regs_pkg::STATUS_OFS:
               s_d.rdata = status;
            default:
               s_d.rdata = 8'h00;
         endcase
      end
   end

   // Reset puts K28.5 in the idle register
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q      <= '0;
         s_q.idle <= {asi_regs_pkg::IDLE_HIGH_RST,
                      asi_regs_pkg::IDLE_LOW_RST};
      end else begin
         s_q <= s_d;
      end
   end

   assign out_data     = s_q.out_data;
   assign out_valid    = s_q.out_valid;
   assign out_is_idle  = s_q.out_idle;
   assign loop_thru_en = s_q.loop_en;
   assign reg_rdata    = s_q.rdata;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   sequence s_starved;
      asi_mode && slot_free && !f_valid;
   endsequence
   sequence s_first_edge;
      !s_q.init_done ##1 s_q.init_done;
   endsequence

   // Compare with the character held when the fill was chosen, since a
   // register write in that same cycle only affects later fill words
   property p_idle_fill;
      @(posedge ref_clk) disable iff (!rst_n)
         s_starved |=> out_valid && out_is_idle &&
                       out_data == $past(s_q.idle);
   endproperty
   a_idle_fill: assert property (p_idle_fill)
      else $error("Idle character not inserted");

   property p_idle_reset;
      @(posedge ref_clk) disable iff (!rst_n)
         !s_q.ever_wr |-> s_q.idle == {asi_regs_pkg::IDLE_HIGH_RST,
                                       asi_regs_pkg::IDLE_LOW_RST};
   endproperty
   a_idle_reset: assert property (p_idle_reset)
      else $error("Idle character lost its reset value");

   property p_low_wr;
      @(posedge ref_clk) disable iff (!rst_n)
         reg_wr && reg_addr == asi_regs_pkg::IDLE_LOW_OFS ##1
         reg_rd && reg_addr == asi_regs_pkg::IDLE_LOW_OFS
         |=> reg_rdata == $past(reg_wdata, 2);
   endproperty
   a_low_wr: assert property (p_low_wr)
      else $error("Low idle register did not read back");

   property p_high_wr;
      @(posedge ref_clk) disable iff (!rst_n)
         reg_wr && reg_addr == asi_regs_pkg::IDLE_HIGH_OFS
         |=> s_q.idle[9:8] == $past(reg_wdata[1:0]);
   endproperty
   a_high_wr: assert property (p_high_wr)
      else $error("High idle bits not written");

   property p_variant;
      @(posedge ref_clk) disable iff (!rst_n)
         reg_rd && reg_addr == asi_regs_pkg::STATUS_OFS
         |=> reg_rdata[asi_regs_pkg::VARIANT_MSB:0] ==
             asi_regs_pkg::VARIANT_ID;
   endproperty
   a_variant: assert property (p_variant)
      else $error("Variant code wrong");

   property p_loop_bit;
      @(posedge ref_clk) disable iff (!rst_n)
         reg_rd && reg_addr == asi_regs_pkg::STATUS_OFS
         |=> reg_rdata[asi_regs_pkg::LOOP_BIT] == $past(loop_thru_en);
   endproperty
   a_loop_bit: assert property (p_loop_bit)
      else $error("Loop enable bit does not match state");

   property p_loop_init;
      @(posedge ref_clk) disable iff (!rst_n)
         s_first_edge |-> loop_thru_en == $past(loop_pin);
   endproperty
   a_loop_init: assert property (p_loop_init)
      else $error("Loop enable not taken from pin");

   property p_state_field;
      @(posedge ref_clk) disable iff (!rst_n)
         reg_rd && reg_addr == asi_regs_pkg::STATUS_OFS
         |=> reg_rdata[asi_regs_pkg::STATE_MSB:asi_regs_pkg::STATE_LSB] ==
             $past(op_state);
   endproperty
   a_state_field: assert property (p_state_field)
      else $error("Operating state field wrong");

   property p_reserved;
      @(posedge ref_clk) disable iff (!rst_n)
         reg_rd && (reg_addr == asi_regs_pkg::IDLE_HIGH_OFS ||
                    reg_addr == asi_regs_pkg::STATUS_OFS)
         |=> reg_rdata[7:6] == 2'b00 &&
             (reg_rdata[5:2] == 4'h0 ||
              $past(reg_addr) == asi_regs_pkg::STATUS_OFS);
   endproperty
   a_reserved: assert property (p_reserved)
      else $error("Reserved bits not zero");
endmodule

// File: rtl/asi_regs_pkg.sv
// What this block does
// - Idle character fills ASI stream when empty
// - Idle character resets to K28.5, software-writable
// - Low register: idle bits 7:0, reset 83
// - High register: idle bits 9:8, reset 2
// - Status read returns 3-bit variant identification
// - Status bit 5 shows loop-through enable
// - Loop-through enable starts from pin level
// - Status holds read-only two-bit operating state
// - State field bits 4:3; 00,01,10 video
package asi_regs_pkg;

   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] IDLE_LOW_OFS  = 8'h0d;
   localparam logic [7:0] IDLE_HIGH_OFS = 8'h0e;
   localparam logic [7:0] STATUS_OFS    = 8'h1d;

   // ------------------------------------------------------------
   // Reset values and field positions
   // ------------------------------------------------------------
   localparam logic [7:0] IDLE_LOW_RST  = 8'h83;
   localparam logic [1:0] IDLE_HIGH_RST = 2'h2;
   localparam int         LOOP_BIT      = 5;
   localparam int         STATE_LSB     = 3;
   localparam int         STATE_MSB     = 4;
   localparam int         VARIANT_MSB   = 2;
   localparam int         IDLE_W        = 10;
   localparam int         FIFO_DEPTH    = 32;

   // Device variant code; value is arbitrary
   localparam logic [2:0] VARIANT_ID    = 3'h5;

   // Operating-state codes; 00, 01 and 10 all mean standard video
   localparam logic [1:0] STATE_VIDEO_A = 2'h0;
   localparam logic [1:0] STATE_VIDEO_B = 2'h1;
   localparam logic [1:0] STATE_VIDEO_C = 2'h2;

endpackage

// File: test/asi_host_sink.sv
`timescale 1ns/1ns

// ------------------------------------------------------------
// Host-side sink of the parallel stream
// ------------------------------------------------------------
module asi_host_sink (
   input  wire logic ref_clk,
   input  wire logic rst_n,
   input  wire logic hold,
   output      logic out_ready
);
   logic [1:0] cnt_q;

   // Refuse one cycle in four so the output stage must hold its word
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q     <= 2'h0;
         out_ready <= 1'b0;
      end else begin
         cnt_q     <= cnt_q + 2'h1;
         out_ready <= #2 !hold && (cnt_q != 2'h3);
      end
   end
endmodule

// File: test/tb_asi_idle_char_and_status_regs.sv
`timescale 1ns/1ns

module tb_asi_idle_char_and_status_regs;
   logic [9:0]  rx_data = 10'h000, out_data, idle_exp = 10'h283;
   logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rd;
   logic [1:0]  op_state = 2'h0;
   logic        ref_clk = 1'b0, rst_n = 1'b0, rx_valid = 1'b0;
   logic        asi_mode = 1'b0, loop_pin = 1'b1, hold = 1'b0;
   logic        reg_wr = 1'b0, reg_rd = 1'b0;
   logic        rx_ready, out_valid, out_is_idle, out_ready, loop_thru_en;
   logic [31:0] seed = 32'hb7dc96ee;
   int          err_count = 0, check_count = 0, idle_seen = 0, n;
   logic [9:0]  exp_q[$];

   always #25 ref_clk = ~ref_clk;

   asi_idle_regs dut (.ref_clk, .rst_n, .rx_data, .rx_valid, .rx_ready,
      .asi_mode, .op_state, .out_data, .out_valid, .out_is_idle,
      .out_ready, .loop_pin, .loop_thru_en, .reg_addr, .reg_wr,
      .reg_wdata, .reg_rd, .reg_rdata);
   asi_host_sink host (.ref_clk, .rst_n, .hold, .out_ready);

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   // Status byte: top bits zero, loop enable, state, variant
   function automatic logic [7:0] st_exp(input logic lp,
                                         input logic [1:0] st);
      return {2'h0, lp, st, asi_regs_pkg::VARIANT_ID};
   endfunction

   task automatic check(input logic [9:0] seen, input logic [9:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish;
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Strobes are raised just after an edge and held for one edge
   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      #2;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge ref_clk);
      #2;
      reg_wr = 1'b0;
   endtask

   // Write then read the same offset on the very next edge
   task automatic reg_write_read(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      #2;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge ref_clk);
      #2;
      reg_wr = 1'b0;
      reg_rd = 1'b1;
      @(posedge ref_clk);
      #2;
      reg_rd = 1'b0;
      rd = reg_rdata;
   endtask

   task automatic reg_read(input logic [7:0] a);
      @(posedge ref_clk);
      #2;
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge ref_clk);
      #2;
      reg_rd = 1'b0;
      rd = reg_rdata;
   endtask

   // Called just after an edge; waits while the buffer refuses.
   // Valid is left up so words can follow back to back; the caller
   // lowers it before a gap.
   task automatic send(input logic [9:0] d);
      rx_data = d;
      rx_valid = 1'b1;
      while (rx_ready !== 1'b1) begin
         @(posedge ref_clk);
         #2;
      end
      @(posedge ref_clk);
      #2;
      exp_q.push_back(d);
   endtask

   task automatic drain;
      n = 0;
      while (exp_q.size() != 0 && n < 400) begin
         @(posedge ref_clk);
         n++;
      end
      #2;
      check(10'(exp_q.size()), 10'h0);
   endtask

   // Every word the host takes must be idle fill or the next sent word
   always @(posedge ref_clk) begin
      if (rst_n && out_valid && out_ready) begin
         if (out_is_idle) begin
            idle_seen++;
            check(out_data, idle_exp);
         end else begin
            check(10'(exp_q.size() != 0), 10'h1);
            if (exp_q.size() != 0)
               check(out_data, exp_q.pop_front());
         end
      end
   end

   // Hang guard, far beyond the few hundred cycles the tests need
   initial begin
      repeat (8000) @(posedge ref_clk);
      err_count++;
      $display("[ERR] %0t watchdog expired", $time);
      tally_and_finish;
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (2) @(posedge ref_clk);
      #2;
      rst_n = 1'b1;
      reg_read(8'h0d);
      check(rd, 8'h83);
      reg_read(8'h0e);
      check(rd, 8'h02);
      check(loop_thru_en, 1'b1);
      for (int s = 0; s < 3; s++) begin
         op_state = 2'(s);
         reg_read(8'h1d);
         check(rd, st_exp(1'b1, 2'(s)));
      end
      reg_write(8'h1d, 8'hff);
      reg_read(8'h1d);
      check(rd, st_exp(1'b1, 2'h2));
      reg_read(8'h42);
      check(rd, 8'h00);
      // Default fill in ASI mode, then a new character
      asi_mode = 1'b1;
      repeat (20) @(posedge ref_clk);
      #2;
      asi_mode = 1'b0;
      repeat (6) @(posedge ref_clk);
      seed = xs(seed);
      reg_write_read(8'h0d, seed[7:0]);
      check(rd, seed[7:0]);
      reg_write(8'h0e, seed[15:8] | 8'hfc);
      idle_exp = seed[9:0];
      reg_read(8'h0d);
      check(rd, seed[7:0]);
      reg_read(8'h0e);
      check(rd, {6'h0, seed[9:8]});
      // Random words with gaps that the idle character must fill
      asi_mode = 1'b1;
      for (int i = 0; i < 40; i++) begin
         seed = xs(seed);
         send(seed[9:0]);
         if (seed[13:12] != 2'h0) begin
            rx_valid = 1'b0;
            repeat (seed[13:12]) begin
               @(posedge ref_clk);
               #2;
            end
         end
      end
      rx_valid = 1'b0;
      drain;
      check(10'(idle_seen > 20), 10'h1);
      // Fill the buffer with the host stalled, then drain it
      asi_mode = 1'b0;
      repeat (6) @(posedge ref_clk);
      #2;
      hold = 1'b1;
      n = 0;
      while (rx_ready === 1'b1 && n < 40) begin
         seed = xs(seed);
         send(seed[9:0]);
         n++;
      end
      rx_valid = 1'b0;
      check(10'(n == 32 || n == 33), 10'h1);
      hold = 1'b0;
      drain;
      repeat (3) @(posedge ref_clk);
      #2;
      check(out_valid, 1'b0);
      // Second reset with the loop-through pin low
      loop_pin = 1'b0;
      rst_n = 1'b0;
      idle_exp = 10'h283;
      @(posedge ref_clk);
      #2;
      rst_n = 1'b1;
      reg_read(8'h1d);
      check(rd, st_exp(1'b0, 2'h2));
      reg_read(8'h0e);
      check(rd, 8'h02);
      tally_and_finish;
   end
endmodule
